// >>> hw/clkwd_pkg.sv
// constants, register map and carrier types of the clock, watchdog and reset core
package clkwd_pkg;

  // register byte offsets on the AHB-Lite slave
  localparam logic [7:0] OFF_CLK_SEL = 8'h00;
  localparam logic [7:0] OFF_FOSC_CTRL = 8'h04;
  localparam logic [7:0] OFF_WDT_CTRL = 8'h08;
  localparam logic [7:0] OFF_WDT_MATCH = 8'h0C;
  localparam logic [7:0] OFF_WDT_SERVICE = 8'h10;
  localparam logic [7:0] OFF_RESET_CAUSE = 8'h14;
  localparam logic [7:0] OFF_SW_RESET = 8'h18;
  localparam logic [7:0] OFF_INT_STATUS = 8'h1C;
  localparam logic [7:0] OFF_INT_MASK = 8'h20;
  localparam logic [7:0] OFF_CAL_CTRL = 8'h24;
  localparam logic [7:0] OFF_CAL_RESULT = 8'h28;
  localparam logic [7:0] OFF_DIV_BASE = 8'h40;

  localparam int NUM_DIV = 6;
  localparam logic [NUM_DIV-1:0] DIV_FRAC_MASK = 6'h30;
  localparam int FRAC_W = 5;

  // divider register fields
  localparam int DIV_INT_LSB = 0;
  localparam int DIV_FRAC_LSB = 16;
  localparam int DIV_EN_BIT = 31;

  // fast oscillator control fields
  localparam int FOSC_TRIM_LSB = 0;
  localparam int FOSC_FREQ_LSB = 8;
  localparam int FOSC_PDIV_LSB = 16;
  localparam logic [5:0] FOSC_FREQ_MIN_MHZ = 6'h18;
  localparam logic [5:0] FOSC_FREQ_MAX_MHZ = 6'h30;
  localparam logic [5:0] FOSC_FREQ_RST_MHZ = 6'h18;
  localparam logic [1:0] FOSC_PDIV_RST = 2'h0;

  // watchdog control fields
  localparam int WDT_EN_BIT = 0;
  localparam int WDT_RSTMODE_BIT = 1;
  localparam logic [15:0] WDT_MATCH_RST = 16'h0FFF;

  // reset cause and interrupt status bits
  localparam int CAUSE_WDT = 0;
  localparam int CAUSE_SW = 1;
  localparam int CAUSE_EXT = 2;
  localparam int INT_WDT = 0;
  localparam int INT_CAL = 1;
  localparam int INT_CLKSW = 2;

  // clock switch field positions
  localparam int CLKSEL_REQ_BIT = 0;
  localparam int CLKSEL_CUR_BIT = 8;
  localparam int CLKSEL_BUSY_BIT = 9;

  // timing
  localparam int CLK_PERIOD_PS = 5000;
  localparam int RESET_HOLD_NS = 100;
  localparam logic [7:0] RESET_HOLD_CYC = 8'((RESET_HOLD_NS * 1000) / CLK_PERIOD_PS);
  localparam int CLK_SWITCH_GAP_NS = 40;
  localparam logic [3:0] CLK_SWITCH_GAP_CYC =
    4'((CLK_SWITCH_GAP_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS);

  typedef struct packed {
    logic en;
    logic [FRAC_W-1:0] frac;
    logic [15:0] intdiv;
  } div_cfg_s;

  typedef struct packed {
    logic valid;
    logic write;
    logic [7:0] addr;
  } ahb_req_s;

  typedef enum logic [1:0] {
    SW_IDLE = 2'b00,
    SW_GATE_OFF = 2'b01,
    SW_GATE_ON = 2'b10
  } clk_sw_e;

endpackage

// >>> hw/clock_watchdog_reset_core.sv
// clock dividers, glitch-free source switch, fast oscillator control, watchdog and reset cause
`timescale 1ns/1ps
`default_nettype none

// What this block does
// - Six separate dividers each divide the high-frequency clock by a 16-bit value.
// - Dividers four and five add a fractional part for fine baud-rate steps.
// - Every divider output is an enable made on the high-frequency clock, so it is synchronous.
// - A change of clock source gates the clock off, swaps, then gates on, so no runt can occur.
// - The fast oscillator setting resets to 24 MHz and software may set 24 to 48 MHz.
// - A post-divider after the fast oscillator divides by 2, 4 or 8, down to 3 MHz.
// - The trim is loaded from nonvolatile storage and software may rewrite it at run time.
// - A calibration counter measures slow-oscillator ticks in fast-clock cycles.
// - The watchdog counts ticks of the slow oscillator.
// - An unserviced watchdog raises a reset or an interrupt as configured.
// - A watchdog reset sets its bit in the reset-cause record.
// - The reset-cause record survives the system reset it describes.
// - Reset entry on rst_b is asynchronous and returns all state to defined values.
// - A software request and the external pin reset the system like any other source.
module clock_watchdog_reset_core (
  input wire logic clock,
  input wire logic rst_b,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  input wire logic slow_internal_oscillator,
  input wire logic external_reset_pin_b,
  input wire logic [7:0] nv_trim,
  output logic [clkwd_pkg::NUM_DIV-1:0] div_clk_en,
  output logic [7:0] fast_internal_oscillator_trim,
  output logic [5:0] fast_internal_oscillator_mhz,
  output logic [1:0] fast_internal_oscillator_postdiv,
  output logic high_frequency_clock_sel,
  output logic high_frequency_clock_gate_en,
  output logic sys_rst_b,
  output logic irq
);
  import clkwd_pkg::*;

  function automatic logic hit(input logic [7:0] a, input logic [7:0] off);
    hit = (a == off);
  endfunction

  ahb_req_s req_q;
  logic wr_en;
  logic [31:0] rd_d;
  logic soft_clr;
  logic [7:0] hold_cnt_q;
  logic sys_rst_b_q;
  logic ext_s1_q, ext_s2_q;
  logic slow_s1_q, slow_s2_q, slow_s3_q;
  logic slow_tick;
  logic wdt_en_q, wdt_rstmode_q;
  logic [15:0] wdt_match_q, wdt_cnt_q;
  logic wdt_timeout, wdt_rst_evt, wdt_int_evt, sw_rst_evt, rst_req;
  logic [2:0] cause_q, cause_set;
  logic [2:0] int_status_q, int_mask_q, int_set;
  logic [7:0] trim_q;
  logic trim_load_q;
  logic [5:0] freq_q;
  logic [1:0] pdiv_q;
  logic cal_busy_q;
  logic [15:0] cal_ticks_q;
  logic [31:0] cal_fast_q, cal_result_q;
  logic cal_done_evt;
  logic clk_req_q, clk_cur_q, gate_en_q;
  logic [3:0] gap_cnt_q;
  clk_sw_e sw_state_q;
  logic clksw_done_evt;
  div_cfg_s div_cfg_q [NUM_DIV];
  logic [NUM_DIV-1:0] div_pulse_q;
  logic [5:0] freq_wr;

  // ---------------- AHB-Lite slave ----------------
  // zero wait states: every access finishes in its first data phase
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;

  always_ff @(posedge clock or negedge rst_b)
  begin
    if (!rst_b)
      req_q <= '0;
    else if (hready)
      req_q <= '{valid: hsel & htrans[1], write: hwrite, addr: {haddr[7:2], 2'b00}};
  end

  assign wr_en = req_q.valid & req_q.write & ~soft_clr;

  // read data comes straight from the registers during the data phase
  always_comb
  begin
    rd_d = 32'h0000_0000;
    if (hit(req_q.addr, OFF_CLK_SEL))
    begin
      rd_d[CLKSEL_REQ_BIT] = clk_req_q;
      rd_d[CLKSEL_CUR_BIT] = clk_cur_q;
      rd_d[CLKSEL_BUSY_BIT] = (sw_state_q != SW_IDLE);
    end
    else if (hit(req_q.addr, OFF_FOSC_CTRL))
    begin
      rd_d[FOSC_TRIM_LSB +: 8] = trim_q;
      rd_d[FOSC_FREQ_LSB +: 6] = freq_q;
      rd_d[FOSC_PDIV_LSB +: 2] = pdiv_q;
    end
    else if (hit(req_q.addr, OFF_WDT_CTRL))
    begin
      rd_d[WDT_EN_BIT] = wdt_en_q;
      rd_d[WDT_RSTMODE_BIT] = wdt_rstmode_q;
    end
    else if (hit(req_q.addr, OFF_WDT_MATCH))
      rd_d[15:0] = wdt_match_q;
    else if (hit(req_q.addr, OFF_WDT_SERVICE))
      rd_d[15:0] = wdt_cnt_q;
    else if (hit(req_q.addr, OFF_RESET_CAUSE))
      rd_d[2:0] = cause_q;
    else if (hit(req_q.addr, OFF_INT_STATUS))
      rd_d[2:0] = int_status_q;
    else if (hit(req_q.addr, OFF_INT_MASK))
      rd_d[2:0] = int_mask_q;
    else if (hit(req_q.addr, OFF_CAL_CTRL))
    begin
      rd_d[15:0] = cal_ticks_q;
      rd_d[31] = cal_busy_q;
    end
    else if (hit(req_q.addr, OFF_CAL_RESULT))
      rd_d = cal_result_q;
    else
    begin
      for (int i = 0; i < NUM_DIV; i++)
      begin
        if (hit(req_q.addr, OFF_DIV_BASE + 8'(4 * i)))
        begin
          rd_d[DIV_INT_LSB +: 16] = div_cfg_q[i].intdiv;
          rd_d[DIV_FRAC_LSB +: FRAC_W] = div_cfg_q[i].frac;
          rd_d[DIV_EN_BIT] = div_cfg_q[i].en;
        end
      end
    end
  end

  assign hrdata = req_q.valid ? rd_d : 32'h0000_0000;

  // ---------------- input synchronisers ----------------
  always_ff @(posedge clock or negedge rst_b)
  begin
    if (!rst_b)
    begin
      ext_s1_q <= 1'b1;
      ext_s2_q <= 1'b1;
      slow_s1_q <= 1'b0;
      slow_s2_q <= 1'b0;
      slow_s3_q <= 1'b0;
    end
    else
    begin
      ext_s1_q <= external_reset_pin_b;
      ext_s2_q <= ext_s1_q;
      slow_s1_q <= slow_internal_oscillator;
      slow_s2_q <= slow_s1_q;
      slow_s3_q <= slow_s2_q;
    end
  end

  // one pulse per rising edge of the slow oscillator
  assign slow_tick = slow_s2_q & ~slow_s3_q;

  // ---------------- system reset sequencing ----------------
  assign sw_rst_evt = wr_en & hit(req_q.addr, OFF_SW_RESET) & hwdata[0];
  assign rst_req = wdt_rst_evt | sw_rst_evt | ~ext_s2_q;

  // the pin holds the system in reset for as long as it stays low
  always_ff @(posedge clock or negedge rst_b)
  begin
    if (!rst_b)
    begin
      hold_cnt_q <= RESET_HOLD_CYC;
      sys_rst_b_q <= 1'b0;
    end
    else
    begin
      if (rst_req)
        hold_cnt_q <= RESET_HOLD_CYC;
      else if (hold_cnt_q != 8'h00)
        hold_cnt_q <= hold_cnt_q - 8'h01;
      sys_rst_b_q <= ~rst_req & (hold_cnt_q <= 8'h01);
    end
  end

  assign soft_clr = (hold_cnt_q != 8'h00);
  assign sys_rst_b = sys_rst_b_q;

  // ---------------- reset cause record ----------------
  assign cause_set = {~ext_s2_q, sw_rst_evt, wdt_rst_evt};

  // cleared by power-on or by writing ones, never by the system reset it records
  always_ff @(posedge clock or negedge rst_b)
  begin
    if (!rst_b)
      cause_q <= 3'h0;
    else if (wr_en && hit(req_q.addr, OFF_RESET_CAUSE))
      cause_q <= (cause_q & ~hwdata[2:0]) | cause_set;
    else
      cause_q <= cause_q | cause_set;
  end

  // ---------------- watchdog ----------------
  always_ff @(posedge clock or negedge rst_b)
  begin
    if (!rst_b)
    begin
      wdt_en_q <= 1'b0;
      wdt_rstmode_q <= 1'b0;
      wdt_match_q <= WDT_MATCH_RST;
    end
    else if (soft_clr)
    begin
      wdt_en_q <= 1'b0;
      wdt_rstmode_q <= 1'b0;
      wdt_match_q <= WDT_MATCH_RST;
    end
    else if (wr_en && hit(req_q.addr, OFF_WDT_CTRL))
    begin
      wdt_en_q <= hwdata[WDT_EN_BIT];
      wdt_rstmode_q <= hwdata[WDT_RSTMODE_BIT];
    end
    else if (wr_en && hit(req_q.addr, OFF_WDT_MATCH))
      wdt_match_q <= hwdata[15:0];
  end

  assign wdt_timeout = wdt_en_q & slow_tick & (wdt_cnt_q >= wdt_match_q);
  assign wdt_rst_evt = wdt_timeout & wdt_rstmode_q;
  assign wdt_int_evt = wdt_timeout & ~wdt_rstmode_q;

  always_ff @(posedge clock or negedge rst_b)
  begin
    if (!rst_b)
      wdt_cnt_q <= 16'h0000;
    else if (soft_clr || !wdt_en_q)
      wdt_cnt_q <= 16'h0000;
    else if (wr_en && hit(req_q.addr, OFF_WDT_SERVICE))
      wdt_cnt_q <= 16'h0000;
    else if (wdt_timeout)
      wdt_cnt_q <= 16'h0000;
    else if (slow_tick)
      wdt_cnt_q <= wdt_cnt_q + 16'h0001;
  end

  // ---------------- interrupts ----------------
  assign int_set = {clksw_done_evt, cal_done_evt, wdt_int_evt};

  always_ff @(posedge clock or negedge rst_b)
  begin
    if (!rst_b)
      int_status_q <= 3'h0;
    else if (soft_clr)
      int_status_q <= 3'h0;
    else if (wr_en && hit(req_q.addr, OFF_INT_STATUS))
      int_status_q <= (int_status_q & ~hwdata[2:0]) | int_set;
    else
      int_status_q <= int_status_q | int_set;
  end

  always_ff @(posedge clock or negedge rst_b)
  begin
    if (!rst_b)
      int_mask_q <= 3'h0;
    else if (soft_clr)
      int_mask_q <= 3'h0;
    else if (wr_en && hit(req_q.addr, OFF_INT_MASK))
      int_mask_q <= hwdata[2:0];
  end

  always_ff @(posedge clock or negedge rst_b)
  begin
    if (!rst_b)
      irq <= 1'b0;
    else
      irq <= |(int_status_q & int_mask_q);
  end

  // ---------------- fast oscillator control ----------------
  always_comb
  begin
    freq_wr = hwdata[FOSC_FREQ_LSB +: 6];
    if (freq_wr < FOSC_FREQ_MIN_MHZ)
      freq_wr = FOSC_FREQ_MIN_MHZ;
    else if (freq_wr > FOSC_FREQ_MAX_MHZ)
      freq_wr = FOSC_FREQ_MAX_MHZ;
  end

  // trim comes from the nonvolatile loader one edge after any reset
  always_ff @(posedge clock or negedge rst_b)
  begin
    if (!rst_b)
      trim_load_q <= 1'b1;
    else
      trim_load_q <= soft_clr;
  end

  always_ff @(posedge clock or negedge rst_b)
  begin
    if (!rst_b)
    begin
      trim_q <= 8'h00;
      freq_q <= FOSC_FREQ_RST_MHZ;
      pdiv_q <= FOSC_PDIV_RST;
    end
    else if (trim_load_q || soft_clr)
    begin
      trim_q <= nv_trim;
      freq_q <= FOSC_FREQ_RST_MHZ;
      pdiv_q <= FOSC_PDIV_RST;
    end
    else if (wr_en && hit(req_q.addr, OFF_FOSC_CTRL))
    begin
      trim_q <= hwdata[FOSC_TRIM_LSB +: 8];
      freq_q <= freq_wr;
      pdiv_q <= hwdata[FOSC_PDIV_LSB +: 2];
    end
  end

  assign fast_internal_oscillator_trim = trim_q;
  assign fast_internal_oscillator_mhz = freq_q;
  assign fast_internal_oscillator_postdiv = pdiv_q;

  // ---------------- slow oscillator calibration ----------------
  assign cal_done_evt = cal_busy_q & slow_tick & (cal_ticks_q == 16'h0001);

  always_ff @(posedge clock or negedge rst_b)
  begin
    if (!rst_b)
    begin
      cal_busy_q <= 1'b0;
      cal_ticks_q <= 16'h0000;
      cal_fast_q <= 32'h0000_0000;
      cal_result_q <= 32'h0000_0000;
    end
    else if (soft_clr)
    begin
      cal_busy_q <= 1'b0;
      cal_ticks_q <= 16'h0000;
      cal_fast_q <= 32'h0000_0000;
    end
    else if (wr_en && hit(req_q.addr, OFF_CAL_CTRL))
    begin
      cal_busy_q <= (hwdata[15:0] != 16'h0000);
      cal_ticks_q <= hwdata[15:0];
      cal_fast_q <= 32'h0000_0000;
    end
    else if (cal_busy_q)
    begin
      // measures from the write to the Nth slow edge; first interval is partial
      cal_fast_q <= cal_fast_q + 32'h0000_0001;
      if (slow_tick)
        cal_ticks_q <= cal_ticks_q - 16'h0001;
      if (cal_done_evt)
      begin
        cal_busy_q <= 1'b0;
        cal_result_q <= cal_fast_q + 32'h0000_0001;
      end
    end
  end

  // ---------------- glitch-free source switch ----------------
  always_ff @(posedge clock or negedge rst_b)
  begin
    if (!rst_b)
      clk_req_q <= 1'b0;
    else if (soft_clr)
      clk_req_q <= 1'b0;
    else if (wr_en && hit(req_q.addr, OFF_CLK_SEL))
      clk_req_q <= hwdata[CLKSEL_REQ_BIT];
  end

  // select only moves while the gate is shut, for a full quiet gap each side
  always_ff @(posedge clock or negedge rst_b)
  begin
    if (!rst_b)
    begin
      sw_state_q <= SW_IDLE;
      clk_cur_q <= 1'b0;
      gate_en_q <= 1'b1;
      gap_cnt_q <= 4'h0;
    end
    else
    begin
      unique case (sw_state_q)
        SW_IDLE:
        begin
          if (clk_req_q != clk_cur_q)
          begin
            gate_en_q <= 1'b0;
            gap_cnt_q <= CLK_SWITCH_GAP_CYC;
            sw_state_q <= SW_GATE_OFF;
          end
        end
        SW_GATE_OFF:
        begin
          if (gap_cnt_q == 4'h0)
          begin
            clk_cur_q <= clk_req_q;
            gap_cnt_q <= CLK_SWITCH_GAP_CYC;
            sw_state_q <= SW_GATE_ON;
          end
          else
            gap_cnt_q <= gap_cnt_q - 4'h1;
        end
        SW_GATE_ON:
        begin
          if (gap_cnt_q == 4'h0)
          begin
            gate_en_q <= 1'b1;
            sw_state_q <= SW_IDLE;
          end
          else
            gap_cnt_q <= gap_cnt_q - 4'h1;
        end
        default:
          sw_state_q <= SW_IDLE;
      endcase
    end
  end

  assign clksw_done_evt = (sw_state_q == SW_GATE_ON) & (gap_cnt_q == 4'h0);
  assign high_frequency_clock_sel = clk_cur_q;
  assign high_frequency_clock_gate_en = gate_en_q;

  // ---------------- peripheral clock dividers ----------------
  generate
    for (genvar g = 0; g < NUM_DIV; g++)
    begin : g_div
      logic [15:0] cnt_q;
      logic [FRAC_W-1:0] acc_q;
      logic [FRAC_W:0] acc_sum;
      logic carry;

      assign acc_sum = {1'b0, acc_q} + {1'b0, div_cfg_q[g].frac};
      assign carry = DIV_FRAC_MASK[g] & acc_sum[FRAC_W];

      always_ff @(posedge clock or negedge rst_b)
      begin
        if (!rst_b)
          div_cfg_q[g] <= '0;
        else if (soft_clr)
          div_cfg_q[g] <= '0;
        else if (wr_en && hit(req_q.addr, OFF_DIV_BASE + 8'(4 * g)))
        begin
          div_cfg_q[g].intdiv <= hwdata[DIV_INT_LSB +: 16];
          div_cfg_q[g].frac <= DIV_FRAC_MASK[g] ? hwdata[DIV_FRAC_LSB +: FRAC_W] : '0;
          div_cfg_q[g].en <= hwdata[DIV_EN_BIT];
        end
      end

      // period is intdiv+1 cycles, one more whenever the fraction overflows
      always_ff @(posedge clock or negedge rst_b)
      begin
        if (!rst_b)
        begin
          cnt_q <= 16'h0000;
          acc_q <= '0;
          div_pulse_q[g] <= 1'b0;
        end
        else if (!div_cfg_q[g].en || soft_clr)
        begin
          // stop at once on system reset, not one edge later with the config
          cnt_q <= 16'h0000;
          acc_q <= '0;
          div_pulse_q[g] <= 1'b0;
        end
        else if (cnt_q == 16'h0000)
        begin
          div_pulse_q[g] <= 1'b1;
          cnt_q <= div_cfg_q[g].intdiv + {15'h0000, carry};
          if (DIV_FRAC_MASK[g])
            acc_q <= acc_sum[FRAC_W-1:0];
        end
        else
        begin
          div_pulse_q[g] <= 1'b0;
          cnt_q <= cnt_q - 16'h0001;
        end
      end
    end
  endgenerate

  assign div_clk_en = div_pulse_q;

endmodule

`default_nettype wire

// >>> sim/clkwd_props.sv
// concurrent checks on the ports of the clock, watchdog and reset core
`timescale 1ns/1ps
`default_nettype none
module clkwd_props
  import clkwd_pkg::*;
(
  input wire logic clock,
  input wire logic rst_b,
  input wire logic hsel,
  input wire logic [1:0] htrans,
  input wire logic hready,
  input wire logic [31:0] hrdata,
  input wire logic hreadyout,
  input wire logic hresp,
  input wire logic external_reset_pin_b,
  input wire logic [clkwd_pkg::NUM_DIV-1:0] div_clk_en,
  input wire logic [5:0] fast_internal_oscillator_mhz,
  input wire logic high_frequency_clock_sel,
  input wire logic high_frequency_clock_gate_en,
  input wire logic sys_rst_b,
  input wire logic irq
);
  default clocking @(posedge clock);
  endclocking
  default disable iff (!rst_b);
  logic acc_q;
  logic [7:0] low_cnt_q;
  // low_cnt_q saturates so a long pin reset cannot wrap it
  always_ff @(posedge clock or negedge rst_b)
  begin
    if (!rst_b)
    begin
      acc_q <= 1'b0;
      low_cnt_q <= 8'h00;
    end
    else
    begin
      acc_q <= hsel && hready && htrans[1];
      low_cnt_q <= sys_rst_b ? 8'h00 : (low_cnt_q == 8'hFF ? 8'hFF : low_cnt_q + 8'h01);
    end
  end
  sequence pin_low_s;
    !external_reset_pin_b [*4];
  endsequence
  sequence gate_off_s;
    $fell(high_frequency_clock_gate_en);
  endsequence
  zero_wait_a: assert property (hreadyout == 1'b1 && hresp == 1'b0)
    else $error("bus answer not ready or not okay");
  idle_rdata_a: assert property (!acc_q |-> hrdata == 32'h00000000)
    else $error("read data driven outside a data phase");
  ext_pin_reset_a: assert property (pin_low_s |-> !sys_rst_b)
    else $error("external pin low without system reset");
  reset_hold_a: assert property ($rose(sys_rst_b) |-> low_cnt_q >= 8'h14)
    else $error("system reset released too early");
  switch_gap_a: assert property (disable iff (!rst_b || !sys_rst_b)
    gate_off_s |-> !high_frequency_clock_gate_en [*8])
    else $error("clock gate reopened too soon");
  sel_after_gap_a: assert property (disable iff (!rst_b || !sys_rst_b)
    gate_off_s |-> ##[7:10] $changed(high_frequency_clock_sel))
    else $error("source did not swap inside the gate gap");
  sel_gated_a: assert property (sys_rst_b && $past(sys_rst_b) && $changed(high_frequency_clock_sel)
    |-> !high_frequency_clock_gate_en && $past(high_frequency_clock_gate_en) == 1'b0)
    else $error("source swapped while clock ungated");
  div_quiet_a: assert property (!sys_rst_b [*2] |-> div_clk_en == '0)
    else $error("divider pulse during system reset");
  irq_quiet_a: assert property (!sys_rst_b [*3] |-> !irq)
    else $error("interrupt high during system reset");
  osc_range_a: assert property (fast_internal_oscillator_mhz >= FOSC_FREQ_MIN_MHZ
    && fast_internal_oscillator_mhz <= FOSC_FREQ_MAX_MHZ)
    else $error("oscillator setting out of range");
endmodule
bind clock_watchdog_reset_core clkwd_props clkwd_props_inst (
  .clock,
  .rst_b,
  .hsel,
  .htrans,
  .hready,
  .hrdata,
  .hreadyout,
  .hresp,
  .external_reset_pin_b,
  .div_clk_en,
  .fast_internal_oscillator_mhz,
  .high_frequency_clock_sel,
  .high_frequency_clock_gate_en,
  .sys_rst_b,
  .irq
);
`default_nettype wire

// >>> sim/testbench.sv
// register-level bench for the clock, watchdog and reset core
`timescale 1ns/1ps
`default_nettype none
module testbench;
  import clkwd_pkg::*;
  logic clock = 1'b0;
  logic rst_b;
  logic hsel;
  logic [31:0] haddr;
  logic [1:0] htrans;
  logic hwrite;
  logic [2:0] hsize;
  logic [31:0] hwdata;
  logic hready;
  logic [31:0] hrdata;
  logic hreadyout;
  logic hresp;
  logic slow_internal_oscillator;
  logic external_reset_pin_b;
  logic [7:0] nv_trim;
  logic [NUM_DIV-1:0] div_clk_en;
  logic [7:0] fast_internal_oscillator_trim;
  logic [5:0] fast_internal_oscillator_mhz;
  logic [1:0] fast_internal_oscillator_postdiv;
  logic high_frequency_clock_sel;
  logic high_frequency_clock_gate_en;
  logic sys_rst_b;
  logic irq;
  logic [31:0] d;
  int n_errors = 0;
  int tests_run = 0;
  int c;
  assign hready = hreadyout;
  always #2.5 clock = ~clock;
  clock_watchdog_reset_core clock_watchdog_reset_core_inst (
    .clock,
    .rst_b,
    .hsel,
    .haddr,
    .htrans,
    .hwrite,
    .hsize,
    .hwdata,
    .hready,
    .hrdata,
    .hreadyout,
    .hresp,
    .slow_internal_oscillator,
    .external_reset_pin_b,
    .nv_trim,
    .div_clk_en,
    .fast_internal_oscillator_trim,
    .fast_internal_oscillator_mhz,
    .fast_internal_oscillator_postdiv,
    .high_frequency_clock_sel,
    .high_frequency_clock_gate_en,
    .sys_rst_b,
    .irq
  );
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp)
    begin
      n_errors++;
      $display("ERROR %0t: got %h, expected %h", $time, got, exp);
    end
  endtask
  // hready and read data taken at the rising edge, before the design updates
  task automatic step(output logic [31:0] r);
    @(posedge clock);
    while (hready !== 1'b1) @(posedge clock);
    r = hrdata;
  endtask
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] wd,
    output logic [31:0] r);
    @(posedge clock);
    hsel <= 1'b1;
    haddr <= {24'h000000, a};
    htrans <= 2'b10;
    hwrite <= w;
    step(r);
    hsel <= 1'b0;
    htrans <= 2'b00;
    hwdata <= wd;
    step(r);
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] wd);
    bus(1'b1, a, wd, d);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    bus(1'b0, a, 32'h00000000, d);
    check(d, exp);
  endtask
  task automatic cyc(input int n);
    repeat (n) @(negedge clock);
  endtask
  task automatic tick(input int n);
    repeat (n)
    begin
      @(posedge clock);
      slow_internal_oscillator <= 1'b1;
      repeat (4) @(posedge clock);
      slow_internal_oscillator <= 1'b0;
      repeat (3) @(posedge clock);
    end
  endtask
  task automatic wait_up;
    int k = 0;
    cyc(3);
    while (sys_rst_b !== 1'b1 && k < 300)
    begin
      cyc(1);
      k++;
    end
    check({31'h0, sys_rst_b}, 32'h00000001);
  endtask
  task automatic span(input int i, input int n);
    int k = 0;
    c = 0;
    while (div_clk_en[i] !== 1'b1 && k < 99)
    begin
      cyc(1);
      k++;
    end
    repeat (n)
    begin
      do
      begin
        cyc(1);
        c++;
      end
      while (div_clk_en[i] !== 1'b1 && c < 999);
    end
  endtask
  task automatic stop_test;
    $display("mismatches %0d, comparisons %0d", n_errors, tests_run);
    if (n_errors == 0 && tests_run > 0)
    begin
      $display("== PASSED ==");
    end
    else
    begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  initial
  begin
    #200000;
    n_errors++;
    $display("ERROR %0t: run did not finish", $time);
    stop_test();
  end
  initial
  begin
    rst_b = 1'b0;
    hsel = 1'b0;
    haddr = 32'h00000000;
    htrans = 2'b00;
    hwrite = 1'b0;
    hsize = 3'h2;
    hwdata = 32'h00000000;
    slow_internal_oscillator = 1'b0;
    external_reset_pin_b = 1'b1;
    nv_trim = 8'hA5;
    repeat (4) @(posedge clock);
    rst_b <= 1'b1;
    wait_up();
    rd(OFF_FOSC_CTRL, 32'h000018A5);
    rd(OFF_WDT_MATCH, 32'h00000FFF);
    rd(OFF_RESET_CAUSE, 32'h00000000);
    wr(8'h30, 32'hFFFFFFFF);
    rd(8'h30, 32'h00000000);
    for (int p = 0; p < 4; p++)
    begin
      wr(OFF_FOSC_CTRL, {14'h0000, 2'(p), 8'h30, 8'(p + 60)});
      rd(OFF_FOSC_CTRL, {14'h0000, 2'(p), 8'h30, 8'(p + 60)});
      check({30'h0, fast_internal_oscillator_postdiv}, 32'(p));
      check({24'h0, fast_internal_oscillator_trim}, 32'(p + 60));
    end
    // settings outside the range are pulled to the nearest bound
    wr(OFF_FOSC_CTRL, 32'h00003F00);
    rd(OFF_FOSC_CTRL, 32'h00003000);
    check({26'h0, fast_internal_oscillator_mhz}, {26'h0, FOSC_FREQ_MAX_MHZ});
    wr(OFF_FOSC_CTRL, 32'h00000500);
    rd(OFF_FOSC_CTRL, 32'h00001800);
    for (int i = 0; i < NUM_DIV; i++)
    begin
      wr(OFF_DIV_BASE + 8'(4 * i), 32'h80000000 | 32'(i + 2));
      span(i, 1);
      check(32'(c), 32'(i + 3));
      wr(OFF_DIV_BASE + 8'(4 * i), 32'h00000000);
      // half-step fraction: 32 pulses gain 16 cycles on fractional dividers only
      wr(OFF_DIV_BASE + 8'(4 * i), 32'h80100001);
      span(i, 32);
      check(32'(c), DIV_FRAC_MASK[i] ? 32'h00000050 : 32'h00000040);
      wr(OFF_DIV_BASE + 8'(4 * i), 32'h00000000);
    end
    wr(OFF_CLK_SEL, 32'h00000001);
    c = 0;
    while (high_frequency_clock_gate_en === 1'b1 && c < 9)
    begin
      cyc(1);
      c++;
    end
    c = 0;
    while (high_frequency_clock_gate_en === 1'b0 && c < 99)
    begin
      cyc(1);
      c++;
    end
    check(32'(c), 32'(2 * (CLK_SWITCH_GAP_CYC + 1)));
    check({31'h0, high_frequency_clock_sel}, 32'h00000001);
    rd(OFF_CLK_SEL, 32'h00000101);
    rd(OFF_INT_STATUS, 32'h00000004);
    wr(OFF_INT_STATUS, 32'h00000004);
    rd(OFF_INT_STATUS, 32'h00000000);
    wr(OFF_CLK_SEL, 32'h00000000);
    cyc(30);
    rd(OFF_CLK_SEL, 32'h00000000);
    wr(OFF_INT_STATUS, 32'h00000004);
    wr(OFF_WDT_MATCH, 32'h00000003);
    wr(OFF_WDT_CTRL, 32'h00000001);
    tick(2);
    rd(OFF_WDT_SERVICE, 32'h00000002);
    wr(OFF_WDT_SERVICE, 32'h00000000);
    rd(OFF_WDT_SERVICE, 32'h00000000);
    tick(3);
    rd(OFF_INT_STATUS, 32'h00000000);
    tick(1);
    rd(OFF_INT_STATUS, 32'h00000001);
    check({31'h0, irq}, 32'h00000000);
    wr(OFF_INT_MASK, 32'h00000001);
    cyc(2);
    check({31'h0, irq}, 32'h00000001);
    wr(OFF_INT_STATUS, 32'h00000001);
    cyc(2);
    check({31'h0, irq}, 32'h00000000);
    wr(OFF_WDT_CTRL, 32'h00000000);
    wr(OFF_CAL_CTRL, 32'h00000002);
    tick(2);
    rd(OFF_CAL_CTRL, 32'h00000000);
    rd(OFF_INT_STATUS, 32'h00000002);
    bus(1'b0, OFF_CAL_RESULT, 32'h00000000, d);
    check({31'h0, d >= 32'h00000008 && d <= 32'h00000014}, 32'h00000001);
    wr(OFF_WDT_MATCH, 32'h00000001);
    wr(OFF_WDT_CTRL, 32'h00000003);
    tick(2);
    check({31'h0, sys_rst_b}, 32'h00000000);
    wait_up();
    rd(OFF_RESET_CAUSE, 32'h00000001);
    rd(OFF_WDT_CTRL, 32'h00000000);
    rd(OFF_FOSC_CTRL, 32'h000018A5);
    // divider left pulsing every cycle so the reset must silence it
    wr(OFF_DIV_BASE, 32'h80000000);
    wr(OFF_SW_RESET, 32'h00000001);
    wait_up();
    rd(OFF_RESET_CAUSE, 32'h00000003);
    rd(OFF_DIV_BASE, 32'h00000000);
    @(posedge clock);
    external_reset_pin_b <= 1'b0;
    cyc(8);
    check({31'h0, sys_rst_b}, 32'h00000000);
    @(posedge clock);
    external_reset_pin_b <= 1'b1;
    wait_up();
    rd(OFF_RESET_CAUSE, 32'h00000007);
    wr(OFF_RESET_CAUSE, 32'h00000002);
    rd(OFF_RESET_CAUSE, 32'h00000005);
    // entry is checked well before the next edge to prove it is not clocked
    @(posedge clock);
    rst_b <= 1'b0;
    #1;
    check({31'h0, sys_rst_b}, 32'h00000000);
    repeat (4) @(posedge clock);
    rst_b <= 1'b1;
    wait_up();
    rd(OFF_RESET_CAUSE, 32'h00000000);
    stop_test();
  end
endmodule
`default_nettype wire
